// >>> hw/ric_defs.vh
// Constants for the reset and interrupt control block.
// Assumes an 11-bit CPU address space and 8-bit CPU data.
`ifndef RIC_DEFS_VH
`define RIC_DEFS_VH

// Register byte addresses on APB
`define RIC_ADDR_WDOG      12'h7f0
`define RIC_ADDR_STATUS    12'h7f4
`define RIC_ADDR_CONTROL   12'h7f8

// Field positions
`define RIC_WDOG_CLEAR_BIT 0
`define RIC_CTL_EXT_EN_BIT 0
`define RIC_CCR_MASK_BIT   3

// Reset values and stack page
`define RIC_CTL_RESET      1'b1
`define RIC_SP_RESET       8'hff
`define RIC_SP_PAGE        3'h0

// Vector pairs, high byte first
`define RIC_VEC_RESET      11'h7fe
`define RIC_VEC_SOFT       11'h7fc
`define RIC_VEC_EXT        11'h7fa
`define RIC_VEC_TIMER      11'h7f8

// Legal opcode fetch ranges
`define RIC_RAM_LO         11'h0c0
`define RIC_RAM_HI         11'h0ff
`define RIC_ROM_LO         11'h300
`define RIC_ROM_HI         11'h7ff

// Power-up stabilisation, in internal cycles
`define RIC_STAB_CYCLES    12'd4064

// Stack byte count per entry
`define RIC_STACK_BYTES    3'd5

`endif

// >>> hw/ric_top.v
// Reset merging, external interrupt latching, timer request gating and the CPU entry/return sequencer.
// Assumes a CPU on I_CLK_SYS that halts while O_CPU_HOLD is high and memory that
// returns read data one cycle after O_MEM_RD.
`include "ric_defs.vh"

module ric_top
(
  // Clock and reset
  input  wire        I_CLK_SYS,
  input  wire        I_RST,
  // Pins and option straps
  input  wire        I_RESET_PIN_N,
  input  wire        I_IRQ_PIN_N,
  input  wire [3:0]  I_PORT_LOW_NIBBLE_PINS,
  input  wire        I_PORT_IRQ_PIN_OPTION,
  input  wire        I_LEVEL_SENSE_OPTION,
  // Peripheral events
  input  wire        I_WDOG_TIMEOUT,
  input  wire        I_PERIODIC_TICK_FLAG,
  input  wire        I_PERIODIC_TICK_ENABLE,
  input  wire        I_COUNTER_WRAP_FLAG,
  input  wire        I_COUNTER_WRAP_ENABLE,
  // CPU status
  input  wire        I_INSTR_DONE,
  input  wire        I_SOFT_TRAP,
  input  wire        I_RETURN_FROM_HANDLER,
  input  wire        I_MASK_SET,
  input  wire        I_MASK_CLEAR,
  input  wire        I_FETCH,
  input  wire [10:0] I_FETCH_ADDR,
  input  wire [10:0] I_PC,
  input  wire [7:0]  I_INDEX,
  input  wire [7:0]  I_ACC,
  input  wire [7:0]  I_CCR,
  // CPU control
  output reg         O_CPU_RESET,
  output reg         O_CPU_HOLD,
  output reg         O_MASK,
  output reg         O_PC_LOAD,
  output reg  [10:0] O_PC,
  output reg         O_RESTORE_LOAD,
  output reg  [2:0]  O_RESTORE_SEL,
  output reg  [7:0]  O_RESTORE_DATA,
  output reg         O_WATCHDOG_CLEAR,
  // Memory port
  output reg         O_MEM_RD,
  output reg         O_MEM_WR,
  output reg  [10:0] O_MEM_ADDR,
  output reg  [7:0]  O_MEM_WDATA,
  input  wire [7:0]  I_MEM_RDATA,
  // APB
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR
);

  localparam [2:0] ST_RESET = 3'd0;
  localparam [2:0] ST_RUN   = 3'd1;
  localparam [2:0] ST_PUSH  = 3'd2;
  localparam [2:0] ST_VEC   = 3'd3;
  localparam [2:0] ST_PULL  = 3'd4;

  localparam [1:0] SRC_SOFT  = 2'd0;
  localparam [1:0] SRC_EXT   = 2'd1;
  localparam [1:0] SRC_TIMER = 2'd2;

  function legal_fetch;
    input [10:0] addr;
    begin
      legal_fetch = ((addr >= `RIC_RAM_LO) && (addr <= `RIC_RAM_HI)) ||
                    ((addr >= `RIC_ROM_LO) && (addr <= `RIC_ROM_HI));
    end
  endfunction

  function [10:0] stack_addr;
    input [7:0] sp_val;
    begin
      stack_addr = {`RIC_SP_PAGE, sp_val};
    end
  endfunction

  // Pin synchronisers
  reg [1:0] rst_pin_sync;
  reg [1:0] irq_sync;
  reg [3:0] port_sync1;
  reg [3:0] port_sync2;
  reg [1:0] opt_sync1;
  reg [1:0] opt_sync2;
  reg       irq_prev;
  reg [3:0] port_prev;

  always @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      rst_pin_sync <= 2'h3;
      irq_sync     <= 2'h3;
      port_sync1   <= 4'h0;
      port_sync2   <= 4'h0;
      opt_sync1    <= 2'h0;
      opt_sync2    <= 2'h0;
      irq_prev     <= 1'b1;
      port_prev    <= 4'h0;
    end
    else
    begin
      rst_pin_sync <= {rst_pin_sync[0], I_RESET_PIN_N};
      irq_sync     <= {irq_sync[0], I_IRQ_PIN_N};
      port_sync1   <= I_PORT_LOW_NIBBLE_PINS;
      port_sync2   <= port_sync1;
      opt_sync1    <= {I_PORT_IRQ_PIN_OPTION, I_LEVEL_SENSE_OPTION};
      opt_sync2    <= opt_sync1;
      irq_prev     <= irq_sync[1];
      port_prev    <= port_sync2;
    end
  end

  wire port_irq_pin_option = opt_sync2[1];
  wire level_sense         = opt_sync2[0];
  wire pin_reset           = ~rst_pin_sync[1];
  wire [3:0] port_used     = port_irq_pin_option ? 4'hf : 4'h0;
  wire irq_event = (irq_prev & ~irq_sync[1]) | (level_sense & ~irq_sync[1]);
  wire port_event = |(port_used & ((~port_prev & port_sync2) | ({4{level_sense}} & port_sync2)));

  // State
  reg [2:0]  state;
  reg [1:0]  src;
  reg [2:0]  step;
  reg [7:0]  sp;
  reg [11:0] stab_cnt;
  reg        event_reset;
  reg        wdog_hit;
  reg        fetch_hit;
  reg        ext_latch;
  reg        ext_request_enable;
  reg [3:0]  reset_cause;
  reg [10:0] vec_addr;
  reg [7:0]  vec_hi;

  wire timer_req = (I_PERIODIC_TICK_FLAG & I_PERIODIC_TICK_ENABLE) |
                   (I_COUNTER_WRAP_FLAG & I_COUNTER_WRAP_ENABLE);
  wire ext_req   = ext_latch & ext_request_enable;
  wire any_src   = pin_reset | event_reset;
  wire entry_clr = (state == ST_RUN) & I_INSTR_DONE & ~I_SOFT_TRAP & ext_req & ~O_MASK;

  // Watchdog or illegal fetch is a one-cycle event; register it so the
  // sequencer sees a clean request even if the source drops at once.
  always @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      event_reset <= 1'b0;
      wdog_hit    <= 1'b0;
      fetch_hit   <= 1'b0;
    end
    else
    begin
      // Cause bits travel with the registered event, not the gone source
      event_reset <= I_WDOG_TIMEOUT | (I_FETCH & ~legal_fetch(I_FETCH_ADDR));
      wdog_hit    <= I_WDOG_TIMEOUT;
      fetch_hit   <= I_FETCH & ~legal_fetch(I_FETCH_ADDR);
    end
  end

  // External request latch; a new event beats the entry clear
  always @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
      ext_latch <= 1'b0;
    else if (state == ST_RESET)
      ext_latch <= 1'b0;
    else if (irq_event | port_event)
      ext_latch <= 1'b1;
    else if (entry_clr)
      ext_latch <= 1'b0;
  end

  // Sequencer
  always @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      state            <= ST_RESET;
      src              <= SRC_SOFT;
      step             <= 3'd0;
      sp               <= `RIC_SP_RESET;
      stab_cnt         <= `RIC_STAB_CYCLES;
      vec_addr         <= `RIC_VEC_RESET;
      vec_hi           <= 8'h00;
      reset_cause      <= 4'h1;
      O_CPU_RESET      <= 1'b1;
      O_CPU_HOLD       <= 1'b1;
      O_MASK           <= 1'b1;
      O_PC_LOAD        <= 1'b0;
      O_PC             <= 11'h000;
      O_RESTORE_LOAD   <= 1'b0;
      O_RESTORE_SEL    <= 3'd0;
      O_RESTORE_DATA   <= 8'h00;
      O_MEM_RD         <= 1'b0;
      O_MEM_WR         <= 1'b0;
      O_MEM_ADDR       <= 11'h000;
      O_MEM_WDATA      <= 8'h00;
    end
    else
    begin
      O_PC_LOAD      <= 1'b0;
      O_RESTORE_LOAD <= 1'b0;
      O_MEM_RD       <= 1'b0;
      O_MEM_WR       <= 1'b0;
      if (any_src)
      begin
        // Abort whatever runs; hold until every source has gone
        state       <= ST_RESET;
        O_CPU_RESET <= 1'b1;
        O_CPU_HOLD  <= 1'b1;
        O_MASK      <= 1'b1;
        sp          <= `RIC_SP_RESET;
        reset_cause <= {fetch_hit, wdog_hit, pin_reset, 1'b0};
      end
      else
      begin
        case (state)
          ST_RESET:
          begin
            if (stab_cnt != 12'd0)
              stab_cnt <= stab_cnt - 12'd1;
            else
            begin
              // First edge with all sources clear and stab_cnt at zero starts the vector fetch
              state       <= ST_VEC;
              step        <= 3'd0;
              vec_addr    <= `RIC_VEC_RESET;
              O_CPU_RESET <= 1'b0;
            end
          end
          ST_RUN:
          begin
            if (I_MASK_SET)
              O_MASK <= 1'b1;
            else if (I_MASK_CLEAR)
              O_MASK <= 1'b0;
            if (I_INSTR_DONE)
            begin
              step <= 3'd0;
              if (I_SOFT_TRAP)
              begin
                state      <= ST_PUSH;
                src        <= SRC_SOFT;
                O_CPU_HOLD <= 1'b1;
              end
              else if (ext_req & ~O_MASK)
              begin
                state      <= ST_PUSH;
                src        <= SRC_EXT;
                O_CPU_HOLD <= 1'b1;
              end
              else if (timer_req & ~O_MASK)
              begin
                state      <= ST_PUSH;
                src        <= SRC_TIMER;
                O_CPU_HOLD <= 1'b1;
              end
              else if (I_RETURN_FROM_HANDLER)
              begin
                state      <= ST_PULL;
                O_CPU_HOLD <= 1'b1;
              end
            end
          end
          ST_PUSH:
          begin
            O_MEM_WR   <= 1'b1;
            O_MEM_ADDR <= stack_addr(sp);
            sp         <= sp - 8'd1;
            step       <= step + 3'd1;
            case (step)
              3'd0:    O_MEM_WDATA <= I_PC[7:0];
              3'd1:    O_MEM_WDATA <= {5'h00, I_PC[10:8]};
              3'd2:    O_MEM_WDATA <= I_INDEX;
              3'd3:    O_MEM_WDATA <= I_ACC;
              default: O_MEM_WDATA <= I_CCR;
            endcase
            if (step == `RIC_STACK_BYTES - 3'd1)
            begin
              // Mask goes up only once the condition codes are out
              O_MASK   <= 1'b1;
              state    <= ST_VEC;
              step     <= 3'd0;
              vec_addr <= (src == SRC_SOFT) ? `RIC_VEC_SOFT :
                          (src == SRC_EXT)  ? `RIC_VEC_EXT : `RIC_VEC_TIMER;
            end
          end
          ST_VEC:
          begin
            step <= step + 3'd1;
            if (step == 3'd0)
            begin
              O_MEM_RD   <= 1'b1;
              O_MEM_ADDR <= vec_addr;
            end
            else if (step == 3'd1)
            begin
              O_MEM_RD   <= 1'b1;
              O_MEM_ADDR <= vec_addr + 11'd1;
            end
            else if (step == 3'd2)
              vec_hi <= I_MEM_RDATA;
            else
            begin
              O_PC       <= {vec_hi[2:0], I_MEM_RDATA};
              O_PC_LOAD  <= 1'b1;
              O_CPU_HOLD <= 1'b0;
              state      <= ST_RUN;
            end
          end
          ST_PULL:
          begin
            // Reads issued in steps 0-4, data captured in steps 2-6
            step <= step + 3'd1;
            if (step < `RIC_STACK_BYTES)
            begin
              O_MEM_RD   <= 1'b1;
              O_MEM_ADDR <= stack_addr(sp + 8'd1);
              sp         <= sp + 8'd1;
            end
            if (step >= 3'd2)
            begin
              O_RESTORE_LOAD <= 1'b1;
              O_RESTORE_SEL  <= step - 3'd2;
              O_RESTORE_DATA <= I_MEM_RDATA;
              if (step == 3'd2)
                O_MASK <= I_MEM_RDATA[`RIC_CCR_MASK_BIT];
              if (step == 3'd6)
              begin
                O_CPU_HOLD <= 1'b0;
                state      <= ST_RUN;
              end
            end
          end
          default:
            state <= ST_RESET;
        endcase
      end
    end
  end

  // APB slave: one wait cycle, answer registered
  wire apb_access = PSEL & PENABLE;
  wire apb_done   = apb_access & PREADY;
  wire hit_wdog   = (PADDR == `RIC_ADDR_WDOG);
  wire hit_status = (PADDR == `RIC_ADDR_STATUS);
  wire hit_ctl    = (PADDR == `RIC_ADDR_CONTROL);

  always @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      PREADY             <= 1'b0;
      PRDATA             <= 32'h00000000;
      PSLVERR            <= 1'b0;
      O_WATCHDOG_CLEAR   <= 1'b0;
      ext_request_enable <= `RIC_CTL_RESET;
    end
    else
    begin
      PREADY           <= apb_access & ~PREADY;
      O_WATCHDOG_CLEAR <= 1'b0;
      if (apb_access & ~PREADY)
      begin
        PSLVERR <= ~(hit_wdog | hit_status | hit_ctl) | (hit_status & PWRITE);
        if (~PWRITE & hit_status)
          PRDATA <= {22'h000000, state, reset_cause, ext_latch, O_MASK, timer_req};
        else if (~PWRITE & hit_ctl)
          PRDATA <= {31'h00000000, ext_request_enable};
        else
          PRDATA <= 32'h00000000;
      end
      else
      begin
        PSLVERR <= 1'b0;
        PRDATA  <= 32'h00000000;
      end
      if (apb_done & PWRITE & hit_wdog & ~PWDATA[`RIC_WDOG_CLEAR_BIT])
        O_WATCHDOG_CLEAR <= 1'b1;
      if (state == ST_RESET)
        ext_request_enable <= `RIC_CTL_RESET;
      else if (apb_done & PWRITE & hit_ctl)
        ext_request_enable <= PWDATA[`RIC_CTL_EXT_EN_BIT];
    end
  end

endmodule

// >>> testbench/ric_mem_model.sv
// Behavioural memory on the sequencer's memory port: vectors and stack page.
// Assumes one clock; read data arrives in the cycle after the read strobe.
module ric_mem_model
(
  // Clock
  input  wire logic        i_clk,
  // Memory port
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  input  wire logic [10:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  output logic      [7:0]  o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:2047];

  // Distinct low bytes catch a swapped vector pair
  initial
  begin
    o_rdata = 8'h5a;
    for (int i = 0; i < 4; i++)
    begin
      mem[11'h7f8 + 2 * i] = 8'h06 - i;
      mem[11'h7f9 + 2 * i] = 8'h11 + 8'h10 * i;
    end
  end

  // Released bus shows no stale byte
  always @(posedge i_clk)
  begin
    o_rdata <= i_rd ? mem[i_addr] : ~o_rdata;
    if (i_wr)
      mem[i_addr] <= i_wdata;
  end
endmodule

// >>> testbench/ric_properties.sv
// Port-level checks of reset merging and the entry/return sequencer.
// Assumes it is bound into ric_top and sees only that module's ports.
`include "ric_defs.vh"
module ric_properties
(
  // Clock and reset
  input wire        I_CLK_SYS,
  input wire        I_RST,
  // Inputs
  input wire        I_RESET_PIN_N,
  input wire        I_WDOG_TIMEOUT,
  input wire        I_INSTR_DONE,
  input wire        I_SOFT_TRAP,
  input wire        I_RETURN_FROM_HANDLER,
  input wire        I_FETCH,
  input wire [10:0] I_FETCH_ADDR,
  // Outputs
  input wire        O_CPU_RESET,
  input wire        O_CPU_HOLD,
  input wire        O_MASK,
  input wire        O_RESTORE_LOAD,
  input wire [2:0]  O_RESTORE_SEL,
  input wire        O_WATCHDOG_CLEAR,
  input wire        O_MEM_RD,
  input wire        O_MEM_WR,
  input wire [10:0] O_MEM_ADDR,
  // APB
  input wire        PSEL,
  input wire        PENABLE,
  input wire        PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  input wire        PREADY
);
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_RST);

  sequence s_stack;
    O_MEM_WR ##1 (O_MEM_WR && O_MEM_ADDR == $past(O_MEM_ADDR) - 11'h1) [*4];
  endsequence
  sequence s_vec;
    O_MEM_RD && O_MEM_ADDR[10:3] == 8'hff && !O_MEM_ADDR[0] ##1 O_MEM_RD && O_MEM_ADDR[0];
  endsequence
  sequence s_restore;
    O_RESTORE_LOAD && O_RESTORE_SEL == 3'h0
      ##1 (O_RESTORE_LOAD && O_RESTORE_SEL == $past(O_RESTORE_SEL) + 3'h1) [*4];
  endsequence

  AST_ENTRY: assert property (I_INSTR_DONE && I_SOFT_TRAP && !O_CPU_HOLD && !O_CPU_RESET
    |=> O_CPU_HOLD ##1 s_stack ##1 s_vec) else $error("entry sequence wrong");
  AST_MASK_SET: assert property (s_stack ##1 O_MEM_RD |-> O_MASK)
    else $error("mask not set before vector");
  AST_RETURN: assert property (I_INSTR_DONE && I_RETURN_FROM_HANDLER && !I_SOFT_TRAP
    && O_MASK && !O_CPU_HOLD |=> O_CPU_HOLD ##1 O_MEM_RD ##2 s_restore) else $error("return order wrong");
  AST_MASK_BLOCK: assert property (I_INSTR_DONE && O_MASK && !I_SOFT_TRAP && !I_RETURN_FROM_HANDLER
    && !O_CPU_HOLD && !I_WDOG_TIMEOUT |=> !O_CPU_HOLD) else $error("masked request served");
  AST_WDOG_CLR: assert property (PSEL && PENABLE && PREADY && PWRITE && PADDR == 12'h7f0
    |=> O_WATCHDOG_CLEAR == !$past(PWDATA[0])) else $error("watchdog clear wrong");
  AST_WDOG_RST: assert property (I_WDOG_TIMEOUT |-> ##[1:3] O_CPU_RESET)
    else $error("no watchdog reset");
  AST_PIN_RST: assert property (!I_RESET_PIN_N [*2] |-> ##[0:4] O_CPU_RESET)
    else $error("no pin reset");
  AST_PIN_EXIT: assert property ($rose(I_RESET_PIN_N) |-> ##2 O_CPU_RESET ##[1:4] !O_CPU_RESET)
    else $error("pin reset exit timing wrong");
  AST_ILLEGAL: assert property (I_FETCH && !O_CPU_HOLD && !O_CPU_RESET
    && !((I_FETCH_ADDR >= `RIC_RAM_LO && I_FETCH_ADDR <= `RIC_RAM_HI) || I_FETCH_ADDR >= `RIC_ROM_LO)
    |-> ##[1:3] O_CPU_RESET) else $error("no illegal fetch reset");
endmodule

bind ric_top ric_properties u_props (.*);

// >>> testbench/tb_top.sv
// Self-checking bench for the reset and interrupt control block.
// Assumes ric_top, the memory model and the bound checker.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        I_CLK_SYS = 1'b0, I_RST = 1'b1, I_RESET_PIN_N = 1'b1, I_IRQ_PIN_N = 1'b1;
  logic        I_PORT_IRQ_PIN_OPTION = 1'b0, I_LEVEL_SENSE_OPTION = 1'b0, I_WDOG_TIMEOUT = 1'b0;
  logic        I_PERIODIC_TICK_FLAG = 1'b0, I_PERIODIC_TICK_ENABLE = 1'b0;
  logic        I_COUNTER_WRAP_FLAG = 1'b0, I_COUNTER_WRAP_ENABLE = 1'b0, I_INSTR_DONE = 1'b0;
  logic        I_SOFT_TRAP = 1'b0, I_RETURN_FROM_HANDLER = 1'b0, I_MASK_SET = 1'b0;
  logic        I_MASK_CLEAR = 1'b0, I_FETCH = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [3:0]  I_PORT_LOW_NIBBLE_PINS = 4'h0;
  logic [10:0] I_FETCH_ADDR = 11'h300, I_PC = 11'h123, O_PC, O_MEM_ADDR, pcv;
  logic [7:0]  I_INDEX = 8'h45, I_ACC = 8'h67, I_CCR = 8'h00;
  logic [7:0]  O_RESTORE_DATA, O_MEM_WDATA, I_MEM_RDATA;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic        O_CPU_RESET, O_CPU_HOLD, O_MASK, O_PC_LOAD, O_RESTORE_LOAD, O_WATCHDOG_CLEAR;
  logic        O_MEM_RD, O_MEM_WR, PREADY, PSLVERR, er, pcl, hit;
  logic [2:0]  O_RESTORE_SEL;
  logic [7:0]  wd [0:4], rs [0:4];
  logic [7:0]  ev [0:3] = '{8'h23, 8'h01, 8'h45, 8'h67};
  int          miscompares = 0, n_checks = 0, cyc = 0, nw;

  ric_top u_dut (.*);
  ric_mem_model u_mem (.i_clk(I_CLK_SYS), .i_rd(O_MEM_RD), .i_wr(O_MEM_WR), .i_addr(O_MEM_ADDR),
    .i_wdata(O_MEM_WDATA), .o_rdata(I_MEM_RDATA));

  always #10 I_CLK_SYS = ~I_CLK_SYS;

  // Whole run is about 5000 cycles
  always @(posedge I_CLK_SYS)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      miscompares++;
      conclude;
    end
  end

  task conclude;
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask

  task clk(input int n);
    repeat (n) @(posedge I_CLK_SYS);
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    clk(1);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    clk(1);
    PENABLE <= 1'b1;
    // Only the bench timeout ends a wait
    do
      clk(1);
    while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // One instruction boundary, then record what the sequencer does
  task bnd(input logic s, input logic r);
    nw = 0;
    pcl = 1'b0;
    clk(1);
    I_INSTR_DONE <= 1'b1;
    I_SOFT_TRAP <= s;
    I_RETURN_FROM_HANDLER <= r;
    clk(1);
    I_INSTR_DONE <= 1'b0;
    I_SOFT_TRAP <= 1'b0;
    I_RETURN_FROM_HANDLER <= 1'b0;
    repeat (14)
    begin
      @(negedge I_CLK_SYS);
      if (O_MEM_WR === 1'b1 && nw < 5)
      begin
        wd[nw] = O_MEM_WDATA;
        nw++;
      end
      if (O_RESTORE_LOAD === 1'b1)
        rs[O_RESTORE_SEL] = O_RESTORE_DATA;
      if (O_PC_LOAD === 1'b1)
      begin
        pcl = 1'b1;
        pcv = O_PC;
      end
    end
  endtask

  task ent(input string s, input logic e, input logic [10:0] v);
    chk(s, e, pcl);
    if (e)
      chk(s, v, pcv);
  endtask

  task rst_wait(input int lo);
    int n;
    n = 0;
    while (O_PC_LOAD !== 1'b1 && n < 5000)
    begin
      @(negedge I_CLK_SYS);
      n++;
    end
    chk("reset_time", 1'b1, n >= lo && n < lo + 40);
    chk("reset_pc", 11'h341, O_PC);
    chk("reset_mask", 1'b1, O_MASK);
  endtask

  task pm(input logic s);
    clk(1);
    I_MASK_SET <= s;
    I_MASK_CLEAR <= !s;
    clk(1);
    I_MASK_SET <= 1'b0;
    I_MASK_CLEAR <= 1'b0;
    clk(2);
  endtask

  // Pin events spaced well beyond handler length plus 19 cycles
  task irq_edge;
    clk(30);
    I_IRQ_PIN_N <= 1'b0;
    clk(3);
    I_IRQ_PIN_N <= 1'b1;
    clk(4);
  endtask

  task tmr(input logic [3:0] v);
    clk(1);
    {I_PERIODIC_TICK_FLAG, I_PERIODIC_TICK_ENABLE, I_COUNTER_WRAP_FLAG, I_COUNTER_WRAP_ENABLE} <= v;
  endtask

  task t_regs;
    apb(1'b0, 12'h7f8, 32'h0);
    chk("ctl_reset", 32'h1, rd);
    apb(1'b0, 12'h7f0, 32'h0);
    chk("wdog_read", 32'h0, rd);
    apb(1'b1, 12'h7f4, 32'h1);
    chk("status_write_err", 1'b1, er);
    apb(1'b0, 12'h7fc, 32'h0);
    chk("unmapped_err", 1'b1, er);
    apb(1'b1, 12'h7f8, 32'h0);
    apb(1'b0, 12'h7f8, 32'h0);
    chk("ctl_rw", 32'h0, rd);
    apb(1'b1, 12'h7f8, 32'h1);
    $display("t_regs done");
  endtask

  // Soft trap taken with the mask still set from reset
  task t_soft;
    bnd(1'b1, 1'b0);
    ent("soft_entry", 1'b1, 11'h431);
    for (int i = 0; i < 4; i++)
      chk("stack_byte", ev[i], wd[i]);
    chk("entry_mask", 1'b1, O_MASK);
    bnd(1'b0, 1'b1);
    for (int i = 0; i < 4; i++)
      chk("restore_byte", ev[i], rs[4 - i]);
    pm(1'b0);
    $display("t_soft done");
  endtask

  task t_ext;
    pm(1'b1);
    irq_edge;
    bnd(1'b0, 1'b0);
    ent("ext_masked", 1'b0, 11'h0);
    pm(1'b0);
    bnd(1'b0, 1'b0);
    ent("ext_entry", 1'b1, 11'h521);
    apb(1'b0, 12'h7f4, 32'h0);
    chk("latch_cleared", 1'b0, rd[2]);
    irq_edge;
    apb(1'b0, 12'h7f4, 32'h0);
    chk("latch_relatched", 1'b1, rd[2]);
    bnd(1'b0, 1'b1);
    bnd(1'b0, 1'b0);
    ent("ext_after_return", 1'b1, 11'h521);
    bnd(1'b0, 1'b1);
    $display("t_ext done");
  endtask

  // Pin held low across a return: serviced again only in level mode
  task t_level(input logic lv);
    clk(1);
    I_LEVEL_SENSE_OPTION <= lv;
    clk(30);
    I_IRQ_PIN_N <= 1'b0;
    clk(4);
    bnd(1'b0, 1'b0);
    ent("level_first", 1'b1, 11'h521);
    bnd(1'b0, 1'b1);
    bnd(1'b0, 1'b0);
    ent("level_held", lv, 11'h521);
    clk(1);
    I_IRQ_PIN_N <= 1'b1;
    if (lv)
      bnd(1'b0, 1'b1);
    clk(6);
    bnd(1'b0, 1'b0);
    if (pcl)
      bnd(1'b0, 1'b1);
    $display("t_level done");
  endtask

  task t_port;
    for (int o = 0; o < 2; o++)
    begin
      clk(1);
      I_PORT_IRQ_PIN_OPTION <= o[0];
      clk(4);
      I_PORT_LOW_NIBBLE_PINS <= 4'h4;
      clk(4);
      I_PORT_LOW_NIBBLE_PINS <= 4'h0;
      clk(4);
      bnd(1'b0, 1'b0);
      ent("port_pin", o[0], 11'h521);
      if (pcl)
        bnd(1'b0, 1'b1);
    end
    $display("t_port done");
  endtask

  task t_timer;
    logic [3:0] tc [0:4];
    tc = '{4'b1100, 4'b1000, 4'b0011, 4'b0010, 4'b0100};
    for (int i = 0; i < 5; i++)
    begin
      tmr(tc[i]);
      bnd(1'b0, 1'b0);
      ent("timer", (tc[i][3] & tc[i][2]) | (tc[i][1] & tc[i][0]), 11'h611);
      tmr(4'h0);
      if (pcl)
        bnd(1'b0, 1'b1);
    end
    irq_edge;
    tmr(4'b0011);
    bnd(1'b0, 1'b0);
    ent("prio_ext", 1'b1, 11'h521);
    bnd(1'b0, 1'b1);
    bnd(1'b0, 1'b0);
    ent("prio_timer", 1'b1, 11'h611);
    tmr(4'h0);
    bnd(1'b0, 1'b1);
    $display("t_timer done");
  endtask

  task t_resets;
    apb(1'b1, 12'h7f0, 32'h0);
    @(negedge I_CLK_SYS);
    chk("wdog_clear", 1'b1, O_WATCHDOG_CLEAR);
    apb(1'b1, 12'h7f0, 32'h1);
    @(negedge I_CLK_SYS);
    chk("wdog_no_clear", 1'b0, O_WATCHDOG_CLEAR);
    tmr(4'h0);
    I_WDOG_TIMEOUT <= 1'b1;
    clk(1);
    I_WDOG_TIMEOUT <= 1'b0;
    rst_wait(1);
    apb(1'b0, 12'h7f4, 32'h0);
    chk("cause_wdog", 1'b1, rd[5]);
    clk(1);
    I_RESET_PIN_N <= 1'b0;
    clk(4);
    I_RESET_PIN_N <= 1'b1;
    rst_wait(3);
    apb(1'b0, 12'h7f4, 32'h0);
    chk("cause_pin", 1'b1, rd[4]);
    $display("t_resets done");
  endtask

  task t_fetch;
    logic [10:0] fa [0:6];
    logic [6:0]  fe;
    fa = '{11'h0bf, 11'h0c0, 11'h0ff, 11'h100, 11'h2ff, 11'h300, 11'h7ff};
    fe = 7'b1001100;
    for (int i = 0; i < 7; i++)
    begin
      clk(2);
      I_FETCH <= 1'b1;
      I_FETCH_ADDR <= fa[i];
      clk(1);
      I_FETCH <= 1'b0;
      hit = 1'b0;
      repeat (4)
      begin
        @(negedge I_CLK_SYS);
        if (O_CPU_RESET === 1'b1)
          hit = 1'b1;
      end
      chk("fetch_reset", fe[6 - i], hit);
      if (hit)
      begin
        rst_wait(1);
        apb(1'b0, 12'h7f4, 32'h0);
        chk("cause_fetch", 1'b1, rd[6]);
      end
    end
    $display("t_fetch done");
  endtask

  initial
  begin
    clk(2);
    I_RST <= 1'b0;
    rst_wait(4064);
    $display("t_poweron done");
    t_regs;
    t_soft;
    t_ext;
    t_level(1'b1);
    t_level(1'b0);
    t_port;
    t_timer;
    t_resets;
    t_fetch;
    conclude;
  end
endmodule
